//--- hdl/pts_timestamp_clock.sv
// Packet timestamp clock: free-running time counter, reference discipline,
// host check, packet stamping and statistics.
// Assumes a 20 MHz clk, a synchronous reset on driver or firmware load,
// and pkt_arrival from logic on clk.
//
// Summary of operation
// - Own time counter, loaded from host, then runs from the local clock.
// - Accepts a once-per-second pulse on the differential sync input.
// - Host time is loaded before any synchronization proceeds.
// - With sync enabled, device seconds checked against host every second.
// - Disagreement over one second reloads host time and restarts sync.
// - Every packet arrival captures a hardware timestamp.
// - Stamp is unsigned 64-bit fixed point seconds, little-endian bytes.
// - Upper half whole seconds, lower half binary fraction.
// - Only 26 fraction bits live; lower bits always zero.
// - Input selector picks one source; none command deselects input and output.
// - Output drives repeat, loopback, master pulse, host source or nothing.
// - Default: differential input selected, output not driven.
// - Set-time loads host time and clears statistics except last phase.
// - Full reset loads time, selects differential input, output off, clears stats but last phase.
// - Programmable health threshold in ns, default 596.
// - Statistics zeroed on load; clear, set-time and full reset zero all but last phase.
// - Phase error over threshold ten consecutive seconds drops sync.
// - Each drop into unsynchronized state counts a failure.
// - Pulses not about one second after the last reference, accepted or late one are bad.
`timescale 1ns/10ps
module pts_timestamp_clock #(
	parameter int P_SEC_CYC = pts_pkg::SEC_CYC,
	parameter int P_TOL_CYC = pts_pkg::TOL_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [31:0] rd_data,
	input  wire logic        sync_in_differential_port,
	input  wire logic        aux_sync_in,
	input  wire logic        pkt_arrival,
	output logic      [63:0] ts_data,
	output logic             ts_valid,
	output logic             sync_out_repeat_differential,
	output logic             sync_out_repeat_differential_en,
	output logic             synced
);
	import pts_pkg::*;

	function automatic logic [31:0] bump(input logic clr, input logic [31:0] v,
		input logic ev);
		bump = (clr ? 32'h0 : v) + {31'h0, ev};
	endfunction

	pts_pps_if pps ();

	logic        rs_m_ff, rs_s_ff, aux_m_ff, aux_s_ff, lvl_ff, nxt_lvl;
	logic [1:0]  ctrl_ff, nxt_ctrl;
	logic [2:0]  in_sel_ff, nxt_in_sel, out_sel_ff, nxt_out_sel;
	logic [31:0] thr_ff, nxt_thr, host_sec_ff, nxt_host_sec;
	logic        cmd_wr, cmd_set, cmd_full, cmd_clr, cmd_def, cmd_none, clr;
	logic [31:0] sec_ff, nxt_sec, sec_diff;
	logic [47:0] acc_ff, nxt_acc, acc_sum, inc_ff, nxt_inc;
	logic        carry, run, reload, mismatch;
	logic        loaded_ff, nxt_loaded, synced_ff, nxt_synced, restart_ff, nxt_restart;
	logic [3:0]  over_ff, nxt_over;
	logic [25:0] err, abs_err;
	logic [46:0] prod;
	logic [31:0] abs_ns, err_ns;
	logic [31:0] total_ff, bad_ff, fail_ff, resync_ff, phase_ff, worst_ff;
	logic [31:0] nxt_total, nxt_bad, nxt_fail, nxt_resync, nxt_phase, nxt_worst;
	logic [63:0] ts_ff, nxt_ts;
	logic        ts_vld_ff, out_ff, nxt_out, out_en_ff, nxt_out_en;
	logic [31:0] rd_ff, nxt_rd;

	assign pps.lvl     = lvl_ff;
	assign pps.restart = restart_ff;
	assign rd_data     = rd_ff;
	assign ts_data     = ts_ff;
	assign ts_valid    = ts_vld_ff;
	assign sync_out_repeat_differential    = out_ff;
	assign sync_out_repeat_differential_en = out_en_ff;
	assign synced      = synced_ff;

	pts_pulse_qual #(
		.P_SEC_CYC (P_SEC_CYC),
		.P_TOL_CYC (P_TOL_CYC)
	) u_qual (
		.clk   (clk),
		.reset (reset),
		.pps   (pps)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and selectors
	always_comb begin
		cmd_wr       = wr_stb && (addr == A_CMD);
		cmd_set      = cmd_wr & wr_data[CMD_SET];
		cmd_full     = cmd_wr & wr_data[CMD_FULL];
		cmd_clr      = cmd_wr & wr_data[CMD_CLR];
		cmd_def      = cmd_wr & wr_data[CMD_DEFAULT];
		cmd_none     = cmd_wr & wr_data[CMD_NONE];
		nxt_ctrl     = ctrl_ff;
		nxt_in_sel   = in_sel_ff;
		nxt_out_sel  = out_sel_ff;
		nxt_thr      = thr_ff;
		nxt_host_sec = host_sec_ff;
		if (wr_stb) begin
			unique case (addr)
				A_CTRL: nxt_ctrl = wr_data[1:0];
				A_THR:  nxt_thr = wr_data;
				A_HOST: nxt_host_sec = wr_data;
				A_SEL: begin
					// Unknown codes are ignored so at most one source stays chosen
					if (wr_data[SEL_IN_LSB +: 3] <= IN_AUX)
						nxt_in_sel = wr_data[SEL_IN_LSB +: 3];
					if (wr_data[SEL_OUT_LSB +: 3] <= OUT_HOST)
						nxt_out_sel = wr_data[SEL_OUT_LSB +: 3];
				end
				default: ;
			endcase
		end
		if (cmd_none) begin
			nxt_in_sel  = IN_NONE;
			nxt_out_sel = OUT_NONE;
		end
		if (cmd_def | cmd_full) begin
			nxt_in_sel  = IN_RS422;
			nxt_out_sel = OUT_NONE;
		end
		unique case (in_sel_ff)
			IN_RS422: nxt_lvl = rs_s_ff;
			IN_HOST:  nxt_lvl = ctrl_ff[CTRL_HOST];
			IN_OVER:  nxt_lvl = ~acc_ff[47];
			IN_AUX:   nxt_lvl = aux_s_ff;
			default:  nxt_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rs_m_ff     <= 1'b0;
			rs_s_ff     <= 1'b0;
			aux_m_ff    <= 1'b0;
			aux_s_ff    <= 1'b0;
			lvl_ff      <= 1'b0;
			ctrl_ff     <= 2'h0;
			in_sel_ff   <= IN_RS422;
			out_sel_ff  <= OUT_NONE;
			thr_ff      <= THR_DEF_NS;
			host_sec_ff <= 32'h0;
		end else begin
			rs_m_ff     <= sync_in_differential_port;
			rs_s_ff     <= rs_m_ff;
			aux_m_ff    <= aux_sync_in;
			aux_s_ff    <= aux_m_ff;
			lvl_ff      <= nxt_lvl;
			ctrl_ff     <= nxt_ctrl;
			in_sel_ff   <= nxt_in_sel;
			out_sel_ff  <= nxt_out_sel;
			thr_ff      <= nxt_thr;
			host_sec_ff <= nxt_host_sec;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Time counter and discipline
	always_comb begin
		{carry, acc_sum} = {1'b0, acc_ff} + {1'b0, inc_ff};
		nxt_acc     = acc_sum;
		nxt_sec     = sec_ff + {31'h0, carry};
		nxt_inc     = inc_ff;
		nxt_loaded  = loaded_ff;
		nxt_synced  = synced_ff;
		nxt_over    = over_ff;
		nxt_restart = 1'b0;
		run         = ctrl_ff[CTRL_SYNC_EN] & loaded_ff;
		err         = acc_ff[47:22];
		abs_err     = err[25] ? 26'(-err) : err;
		prod        = 47'(abs_err) * 47'h1D_CD65;
		abs_ns      = {2'h0, prod[46:17]};
		err_ns      = err[25] ? 32'(-abs_ns) : abs_ns;
		sec_diff    = nxt_sec - host_sec_ff;
		mismatch    = carry & run & (sec_diff != 32'h0) & (sec_diff != 32'h1)
			& (sec_diff != 32'hFFFF_FFFF);
		reload      = cmd_set | cmd_full | mismatch;
		if (reload) begin
			nxt_sec     = host_sec_ff;
			nxt_acc     = 48'h0;
			nxt_loaded  = 1'b1;
			nxt_synced  = 1'b0;
			nxt_over    = 4'h0;
			nxt_restart = 1'b1;
			if (cmd_full)
				nxt_inc = INC_NOM;
		end else if (run & pps.accept) begin
			// Snap phase to the pulse; a fraction past one half means we ran slow
			nxt_acc = {26'h0, acc_ff[21:0]} + inc_ff;
			nxt_sec = sec_ff + {31'h0, acc_ff[47]};
			nxt_inc = inc_ff - 48'($signed({{22{err[25]}}, err}) >>> TRIM_SH);
			if (abs_ns > thr_ff) begin
				nxt_over = (over_ff == HEALTH_SECS) ? over_ff : over_ff + 4'h1;
				if (nxt_over == HEALTH_SECS)
					nxt_synced = 1'b0;
			end else begin
				nxt_over   = 4'h0;
				nxt_synced = 1'b1;
			end
		end
		if (!run)
			nxt_restart = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sec_ff     <= 32'h0;
			acc_ff     <= 48'h0;
			inc_ff     <= INC_NOM;
			loaded_ff  <= 1'b0;
			synced_ff  <= 1'b0;
			over_ff    <= 4'h0;
			restart_ff <= 1'b1;
		end else begin
			sec_ff     <= nxt_sec;
			acc_ff     <= nxt_acc;
			inc_ff     <= nxt_inc;
			loaded_ff  <= nxt_loaded;
			synced_ff  <= nxt_synced;
			over_ff    <= nxt_over;
			restart_ff <= nxt_restart;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Statistics; an event in the clearing cycle still counts
	always_comb begin
		clr        = cmd_set | cmd_full | cmd_clr;
		nxt_total  = bump(clr, total_ff, run & pps.seen);
		nxt_bad    = bump(clr, bad_ff, run & pps.bad);
		nxt_fail   = bump(clr, fail_ff, synced_ff & ~nxt_synced);
		nxt_resync = bump(clr, resync_ff, mismatch);
		nxt_phase  = phase_ff;
		nxt_worst  = clr ? 32'h0 : worst_ff;
		if (run & pps.accept & ~reload) begin
			nxt_phase = err_ns;
			if (abs_ns > nxt_worst)
				nxt_worst = abs_ns;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			total_ff  <= 32'h0;
			bad_ff    <= 32'h0;
			fail_ff   <= 32'h0;
			resync_ff <= 32'h0;
			phase_ff  <= 32'h0;
			worst_ff  <= 32'h0;
		end else begin
			total_ff  <= nxt_total;
			bad_ff    <= nxt_bad;
			fail_ff   <= nxt_fail;
			resync_ff <= nxt_resync;
			phase_ff  <= nxt_phase;
			worst_ff  <= nxt_worst;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stamps, sync output and read port
	always_comb begin
		nxt_ts = pkt_arrival ? {sec_ff, acc_ff[47:22], 6'h0} : ts_ff;
		unique case (out_sel_ff)
			OUT_REPEAT: nxt_out = rs_s_ff;
			OUT_LOOP:   nxt_out = lvl_ff;
			OUT_MASTER: nxt_out = ~acc_ff[47];
			OUT_HOST:   nxt_out = ctrl_ff[CTRL_HOST];
			default:    nxt_out = 1'b0;
		endcase
		nxt_out_en = (out_sel_ff != OUT_NONE);
		nxt_rd     = 32'h0;
		if (rd_stb) begin
			unique case (addr)
				A_CTRL:   nxt_rd = {30'h0, ctrl_ff};
				A_SEL:    nxt_rd = {25'h0, out_sel_ff, 1'b0, in_sel_ff};
				A_THR:    nxt_rd = thr_ff;
				A_HOST:   nxt_rd = host_sec_ff;
				A_TIME_H: nxt_rd = sec_ff;
				A_TIME_L: nxt_rd = {acc_ff[47:22], 6'h0};
				A_STAT:   nxt_rd = {30'h0, loaded_ff, synced_ff};
				A_TOTAL:  nxt_rd = total_ff;
				A_BAD:    nxt_rd = bad_ff;
				A_FAIL:   nxt_rd = fail_ff;
				A_RESYNC: nxt_rd = resync_ff;
				A_PHASE:  nxt_rd = phase_ff;
				A_WORST:  nxt_rd = worst_ff;
				default:  nxt_rd = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ts_ff     <= 64'h0;
			ts_vld_ff <= 1'b0;
			out_ff    <= 1'b0;
			out_en_ff <= 1'b0;
			rd_ff     <= 32'h0;
		end else begin
			ts_ff     <= nxt_ts;
			ts_vld_ff <= pkt_arrival;
			out_ff    <= nxt_out;
			out_en_ff <= nxt_out_en;
			rd_ff     <= nxt_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_full_cmd;
		cmd_full ##1 1'b1;
	endsequence
	sequence s_over_tenth;
		run & pps.accept & ~reload & (abs_ns > thr_ff) & (over_ff == 4'h9);
	endsequence

	property p_stamp;
		pkt_arrival |=> ts_valid && ts_data == {$past(sec_ff), $past(acc_ff[47:22]), 6'h0};
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp mismatch");

	property p_low_zero;
		ts_data[5:0] == 6'h0 && (!($past(rd_stb) && $past(addr) == A_TIME_L)
			|| rd_data[5:0] == 6'h0);
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("dead bits set");

	property p_default;
		cmd_def & ~cmd_none |=> in_sel_ff == IN_RS422 ##1 !sync_out_repeat_differential_en;
	endproperty
	a_default: assert property (p_default) else $error("default cfg wrong");

	property p_none;
		cmd_none & ~cmd_def & ~cmd_full |=> in_sel_ff == IN_NONE && out_sel_ff == OUT_NONE;
	endproperty
	a_none: assert property (p_none) else $error("clear cfg wrong");

	property p_full;
		s_full_cmd |-> loaded_ff && in_sel_ff == IN_RS422 && sec_ff == $past(host_sec_ff)
			&& bad_ff <= 32'h1 && worst_ff == 32'h0;
	endproperty
	a_full: assert property (p_full) else $error("full reset wrong");

	property p_resync;
		mismatch |=> sec_ff == $past(host_sec_ff) && !synced_ff
			&& resync_ff == $past(resync_ff) + 32'h1 || $past(clr);
	endproperty
	a_resync: assert property (p_resync) else $error("host check failed");

	property p_health;
		s_over_tenth |=> !synced_ff && over_ff == HEALTH_SECS;
	endproperty
	a_health: assert property (p_health) else $error("sync not dropped");

	property p_fail;
		synced_ff & ~nxt_synced & ~clr |=> fail_ff == $past(fail_ff) + 32'h1;
	endproperty
	a_fail: assert property (p_fail) else $error("failure not counted");

	property p_bad;
		run & pps.bad & ~clr |=> bad_ff == $past(bad_ff) + 32'h1;
	endproperty
	a_bad: assert property (p_bad) else $error("bad pulse not counted");

	property p_out_off;
		out_sel_ff == OUT_NONE |=> !sync_out_repeat_differential_en
			&& !sync_out_repeat_differential;
	endproperty
	a_out_off: assert property (p_out_off) else $error("output driven");
endmodule

//--- hdl/pts_pkg.sv
// Constants for the packet timestamp clock.
// Assumes a 20 MHz card clock and a 32-bit register port.
package pts_pkg;
	// Timing
	localparam int CLK_HZ       = 20_000_000;
	localparam int PPS_PERIOD_S = 1;
	localparam int PPS_TOL_US   = 1000;
	localparam int SEC_CYC      = CLK_HZ * PPS_PERIOD_S;
	localparam int TOL_CYC      = CLK_HZ / 1_000_000 * PPS_TOL_US;
	localparam logic [3:0] HEALTH_SECS = 4'hA;
	localparam int TRIM_SH      = 2;
	// Timestamp layout: 26 live fraction bits, 6 dead ones
	localparam int FRAC_BITS    = 26;
	localparam int FRAC_DEAD    = 32 - FRAC_BITS;
	// Nominal increment of the 48-bit fraction accumulator per clock
	localparam logic [47:0] INC_NOM    = 48'h0000_00D6_BF95;
	localparam logic [31:0] THR_DEF_NS = 32'h0000_0254;
	// Register offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_CMD    = 8'h04;
	localparam logic [7:0] A_SEL    = 8'h08;
	localparam logic [7:0] A_THR    = 8'h0C;
	localparam logic [7:0] A_HOST   = 8'h10;
	localparam logic [7:0] A_TIME_H = 8'h14;
	localparam logic [7:0] A_TIME_L = 8'h18;
	localparam logic [7:0] A_STAT   = 8'h1C;
	localparam logic [7:0] A_TOTAL  = 8'h20;
	localparam logic [7:0] A_BAD    = 8'h24;
	localparam logic [7:0] A_FAIL   = 8'h28;
	localparam logic [7:0] A_RESYNC = 8'h2C;
	localparam logic [7:0] A_PHASE  = 8'h30;
	localparam logic [7:0] A_WORST  = 8'h34;
	// Field positions
	localparam int CTRL_SYNC_EN = 0;
	localparam int CTRL_HOST    = 1;
	localparam int CMD_SET      = 0;
	localparam int CMD_FULL     = 1;
	localparam int CMD_CLR      = 2;
	localparam int CMD_DEFAULT  = 3;
	localparam int CMD_NONE     = 4;
	localparam int SEL_IN_LSB   = 0;
	localparam int SEL_OUT_LSB  = 4;
	localparam int STAT_SYNCED  = 0;
	localparam int STAT_LOADED  = 1;
	// Selector codes
	localparam logic [2:0] IN_NONE    = 3'h0;
	localparam logic [2:0] IN_RS422   = 3'h1;
	localparam logic [2:0] IN_HOST    = 3'h2;
	localparam logic [2:0] IN_OVER    = 3'h3;
	localparam logic [2:0] IN_AUX     = 3'h4;
	localparam logic [2:0] OUT_NONE   = 3'h0;
	localparam logic [2:0] OUT_REPEAT = 3'h1;
	localparam logic [2:0] OUT_LOOP   = 3'h2;
	localparam logic [2:0] OUT_MASTER = 3'h3;
	localparam logic [2:0] OUT_HOST   = 3'h4;
	typedef enum logic {Q_IDLE, Q_RUN} pts_q_state_t;
endpackage

//--- hdl/pts_pps_if.sv
// Reference pulse link between the clock core and the pulse qualifier.
// Both ends run on the one card clock.
`timescale 1ns/10ps
interface pts_pps_if;
	logic lvl;
	logic restart;
	logic seen;
	logic accept;
	logic bad;
	modport core (output lvl, output restart, input seen, input accept, input bad);
	modport qual (input lvl, input restart, output seen, output accept, output bad);
endinterface

//--- hdl/pts_pulse_qual.sv
// Reference pulse qualifier: edge detect and one-second gap check.
// Assumes lvl is already synchronised to clk.
`timescale 1ns/10ps
module pts_pulse_qual #(
	parameter int P_SEC_CYC = pts_pkg::SEC_CYC,
	parameter int P_TOL_CYC = pts_pkg::TOL_CYC
) (
	input  wire logic clk,
	input  wire logic reset,
	pts_pps_if.qual   pps
);
	import pts_pkg::*;
	localparam logic [25:0] GAP_MIN = 26'(P_SEC_CYC - P_TOL_CYC);
	localparam logic [25:0] GAP_MAX = 26'(P_SEC_CYC + P_TOL_CYC);
	localparam logic [25:0] GAP_SAT = 26'h3FF_FFFF;

	pts_q_state_t state_ff, nxt_state;
	logic [25:0]  gap_ff, nxt_gap;
	logic         lvl_ff, seen_ff, acc_ff, bad_ff;
	logic         nxt_seen, nxt_acc, nxt_bad, rise;

	assign pps.seen   = seen_ff;
	assign pps.accept = acc_ff;
	assign pps.bad    = bad_ff;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		rise      = pps.lvl & ~lvl_ff;
		nxt_state = state_ff;
		nxt_gap   = (gap_ff == GAP_SAT) ? gap_ff : gap_ff + 26'h1;
		nxt_seen  = 1'b0;
		nxt_acc   = 1'b0;
		nxt_bad   = 1'b0;
		if (pps.restart) begin
			nxt_state = Q_IDLE;
		end else if (rise) begin
			nxt_seen = 1'b1;
			unique case (state_ff)
				Q_IDLE: begin
					nxt_state = Q_RUN;
					nxt_gap   = 26'h0;
				end
				Q_RUN: begin
					// Early pulses are noise: keep the old reference
					if (gap_ff < GAP_MIN) begin
						nxt_bad = 1'b1;
					end else if (gap_ff > GAP_MAX) begin
						// Late pulses restart the reference so lock can recover
						nxt_bad = 1'b1;
						nxt_gap = 26'h0;
					end else begin
						nxt_acc = 1'b1;
						nxt_gap = 26'h0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= Q_IDLE;
			gap_ff   <= 26'h0;
			lvl_ff   <= 1'b0;
			seen_ff  <= 1'b0;
			acc_ff   <= 1'b0;
			bad_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			gap_ff   <= nxt_gap;
			lvl_ff   <= pps.lvl;
			seen_ff  <= nxt_seen;
			acc_ff   <= nxt_acc;
			bad_ff   <= nxt_bad;
		end
	end
endmodule

//--- dv/pts_pps_src.sv
// Model of the external pulse-per-second receiver on the differential input.
// Assumes the bench calls send from its main sequence, on the card clock.
`timescale 1ns/10ps
module pts_pps_src (
	input  wire logic clk,
	output logic      pps
);
	initial pps = 1'b0;
	// Receiver drives the line low between pulses, so no idle pattern is needed
	// Gap is counted rise to rise, so early and late pulses are one call each
	task automatic send(input int gap);
		repeat (gap - 4) @(posedge clk);
		pps <= 1'b1;
		repeat (4) @(posedge clk);
		pps <= 1'b0;
	endtask
endmodule

//--- dv/pts_timestamp_clock_test.sv
// Self-checking bench for the packet timestamp clock.
// Assumes a shortened second of 200 cycles in the pulse qualifier.
`timescale 1ns/10ps
module pts_timestamp_clock_test;
	import pts_pkg::*;
	localparam int SEC = 200;
	localparam int TOL = 20;
	logic        clk;
	logic        reset;
	logic [7:0]  addr;
	logic [31:0] wr_data;
	logic        wr_stb;
	logic        rd_stb;
	logic [31:0] rd_data;
	logic        pps;
	logic        aux_sync_in;
	logic        pkt_arrival;
	logic [63:0] ts_data;
	logic        ts_valid;
	logic        sync_out;
	logic        sync_out_en;
	logic        synced;
	logic [31:0] v;
	logic [31:0] d;
	logic [63:0] t0;
	logic [63:0] t1;
	int          bad_count;
	int          comparisons;

	pts_timestamp_clock #(.P_SEC_CYC(SEC), .P_TOL_CYC(TOL)) uut (
		.clk                             (clk),
		.reset                           (reset),
		.addr                            (addr),
		.wr_data                         (wr_data),
		.wr_stb                          (wr_stb),
		.rd_stb                          (rd_stb),
		.rd_data                         (rd_data),
		.sync_in_differential_port       (pps),
		.aux_sync_in                     (aux_sync_in),
		.pkt_arrival                     (pkt_arrival),
		.ts_data                         (ts_data),
		.ts_valid                        (ts_valid),
		.sync_out_repeat_differential    (sync_out),
		.sync_out_repeat_differential_en (sync_out_en),
		.synced                          (synced)
	);
	pts_pps_src src (
		.clk (clk),
		.pps (pps)
	);

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog sized well above the few thousand cycles the tests need
	initial begin
		#(50 * 20000);
		bad_count++;
		close_out();
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk);
		addr    <= a;
		wr_data <= dat;
		wr_stb  <= 1'b1;
		@(posedge clk);
		wr_stb  <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [7:0] a, output logic [31:0] dat);
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 dat = rd_data;
	endtask

	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] got;
		rd(a, got);
		chk(n, {32'h0000_0000, e}, {32'h0000_0000, got});
	endtask

	task automatic stamp(output logic [63:0] t);
		@(posedge clk);
		pkt_arrival <= 1'b1;
		@(posedge clk);
		pkt_arrival <= 1'b0;
		#1 chk("ts_valid", 64'h1, {63'h0, ts_valid});
		t = ts_data;
	endtask

	// Bounded wait for the sync output to go high; looks after the edge has settled
	task automatic see_out(input string n);
		for (int k = 0; k < 12 && sync_out !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		chk(n, 64'h1, {63'h0, sync_out});
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		reset       = 1'b1;
		addr        = 8'h00;
		wr_data     = 32'h0000_0000;
		wr_stb      = 1'b0;
		rd_stb      = 1'b0;
		aux_sync_in = 1'b0;
		pkt_arrival = 1'b0;
		bad_count   = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		// State after load
		chk("out_en", 64'h0, {63'h0, sync_out_en});
		chk("synced", 64'h0, {63'h0, synced});
		rc("thr", A_THR, THR_DEF_NS);
		rc("sel", A_SEL, 32'h0000_0001);
		rc("status", A_STAT, 32'h0000_0000);
		rc("total", A_TOTAL, 32'h0000_0000);
		rc("fail", A_FAIL, 32'h0000_0000);
		rc("unmapped", 8'h3C, 32'h0000_0000);
		wr(A_THR, 32'h0000_0064);
		rc("thr", A_THR, 32'h0000_0064);
		// Set time from host seconds
		wr(A_HOST, 32'h1234_5678);
		wr(A_CMD, 32'h1 << CMD_SET);
		rc("time_h", A_TIME_H, 32'h1234_5678);
		rc("status", A_STAT, 32'h0000_0002);
		rd(A_TIME_L, v);
		chk("frac_dead", 64'h0, {58'h0, v[5:0]});
		// Two stamps ten cycles apart; masking costs at most one live step
		stamp(t0);
		repeat (8) @(posedge clk);
		stamp(t1);
		chk("ts_sec", {32'h0, 32'h1234_5678}, {32'h0, t0[63:32]});
		chk("ts_dead", 64'h0, {58'h0, t1[5:0]});
		d = t1[31:0] - t0[31:0];
		v = 32'((48'd10 * INC_NOM) >> 16);
		chk("ts_adv", 64'h1, {63'h0, (d + 32'd64 >= v) && (d <= v + 32'd64)});
		// Every input and output code
		for (int i = 0; i < 5; i++) begin
			wr(A_SEL, 32'((i << SEL_OUT_LSB) | i));
			rc("sel", A_SEL, 32'((i << SEL_OUT_LSB) | i));
			chk("out_en", {63'h0, i != 0}, {63'h0, sync_out_en});
		end
		wr(A_SEL, 32'h0000_0055);
		rc("sel_bad", A_SEL, 32'h0000_0044);
		wr(A_CMD, 32'h1 << CMD_NONE);
		rc("sel_none", A_SEL, 32'h0000_0000);
		wr(A_CMD, 32'h1 << CMD_DEFAULT);
		rc("sel_def", A_SEL, 32'h0000_0001);
		wr(A_SEL, 32'h0000_0034);
		wr(A_HOST, 32'h0000_0100);
		wr(A_CMD, 32'h1 << CMD_FULL);
		rc("sel_full", A_SEL, 32'h0000_0001);
		rc("time_full", A_TIME_H, 32'h0000_0100);
		chk("en_full", 64'h0, {63'h0, sync_out_en});
		// Output sources
		wr(A_SEL, 32'h0000_0011);
		fork
			src.send(6);
			see_out("repeat");
		join
		wr(A_SEL, 32'h0000_0024);
		@(posedge clk);
		aux_sync_in <= 1'b1;
		see_out("loop");
		aux_sync_in <= 1'b0;
		wr(A_SEL, 32'h0000_0040);
		wr(A_CTRL, 32'h1 << CTRL_HOST);
		see_out("host");
		wr(A_SEL, 32'h0000_0022);
		see_out("host_loop");
		// Fraction is well under one half here, so the master pulse is high
		wr(A_SEL, 32'h0000_0030);
		see_out("master");
		// Pulse qualification: reference, on time, early
		wr(A_SEL, 32'h0000_0001);
		wr(A_CTRL, 32'h1 << CTRL_SYNC_EN);
		wr(A_CMD, 32'h1 << CMD_CLR);
		src.send(10);
		src.send(SEC);
		src.send(SEC / 2);
		repeat (8) @(posedge clk);
		rc("total", A_TOTAL, 32'h0000_0003);
		rc("bad", A_BAD, 32'h0000_0001);
		wr(A_CMD, 32'h1 << CMD_CLR);
		rc("bad_clr", A_BAD, 32'h0000_0000);
		rc("total_clr", A_TOTAL, 32'h0000_0000);
		// Late pulse, then set-time clears the count
		src.send(SEC * 2);
		repeat (8) @(posedge clk);
		rc("bad_late", A_BAD, 32'h0000_0001);
		wr(A_CMD, 32'h1 << CMD_SET);
		rc("bad_set", A_BAD, 32'h0000_0000);
		// Lock under a loose threshold, then ten pulses over a zero one drop it
		wr(A_THR, 32'hFFFF_FFFF);
		src.send(10);
		src.send(SEC);
		repeat (8) @(posedge clk);
		chk("synced_on", 64'h1, {63'h0, synced});
		wr(A_THR, 32'h0000_0000);
		for (int i = 0; i < 10; i++) src.send(SEC);
		repeat (8) @(posedge clk);
		chk("synced_off", 64'h0, {63'h0, synced});
		rc("fail_cnt", A_FAIL, 32'h0000_0001);
		rc("total_cnt", A_TOTAL, 32'h0000_000C);
		rd(A_WORST, v);
		chk("worst_set", 64'h1, {63'h0, v != 32'h0});
		// A logic reload restores the default selectors, then software writes a new selection
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rc("sel_reload", A_SEL, 32'h0000_0001);
		rc("fail_reload", A_FAIL, 32'h0000_0000);
		rc("stat_reload", A_STAT, 32'h0000_0000);
		wr(A_SEL, 32'h0000_0014);
		rc("sel_again", A_SEL, 32'h0000_0014);
		chk("en_again", 64'h1, {63'h0, sync_out_en});
		close_out();
	end
endmodule
